// File: ppio_pkg.sv
package ppio_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned PIN_COUNT  = 32;
	localparam int unsigned BANK_WIDTH = 16;
	localparam int unsigned ADDR_WIDTH = 8;

	// ==========================================================
	// Register offsets inside the peripheral control block
	localparam logic [7:0] OFS_MODE_LO  = 8'h70;
	localparam logic [7:0] OFS_DIR_LO   = 8'h72;
	localparam logic [7:0] OFS_LEVEL_LO = 8'h74;
	localparam logic [7:0] OFS_MODE_HI  = 8'h76;
	localparam logic [7:0] OFS_DIR_HI   = 8'h78;
	localparam logic [7:0] OFS_LEVEL_HI = 8'h7a;

	// ==========================================================
	// Reset values and fixed pin properties
	localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
	localparam logic [31:0] DIR_RESET       = 32'hffff_fc07;
	localparam logic [31:0] LEVEL_RESET     = 32'h0000_0000;
	localparam logic [31:0] OVERRIDE_MASK   = 32'h2400_0000;
	localparam logic [31:0] PULL_DOWN_MASK  = 32'h0000_0402;
	localparam int unsigned SRDY_PIN        = 6;
	localparam logic [15:0] UNMAPPED_READ   = 16'h0000;

	// ==========================================================
	// Pin function, encoded as {mode bit, direction bit}
	typedef enum logic [1:0] {
		PPIO_NORMAL     = 2'h0,
		PPIO_INPUT_PULL = 2'h1,
		PPIO_OUTPUT     = 2'h2,
		PPIO_OPEN_DRAIN = 2'h3
	} ppio_func_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        sel;
		logic        rd;
		logic        wr;
		logic [1:0]  be;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} ppio_pcb_req_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
	} ppio_drive_t;

endpackage

// File: ppio_pin_cell.sv
`timescale 1ns/1ps
module ppio_pin_cell
	import ppio_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire ppio_func_t  func,
	input  wire logic        level_out,
	input  wire logic        pull_down_sel,
	input  wire logic        periph_out,
	input  wire logic        periph_oe,
	input  wire logic        pin_level,
	output ppio_drive_t      drive,
	output logic             periph_in
);

	ppio_drive_t next_drive;
	logic        next_periph_in;

	// ==========================================================
	// Pin steering
	always_comb begin
		next_drive     = '0;
		next_periph_in = 1'b1;
		unique case (func)
			PPIO_NORMAL: begin
				next_drive.out = periph_out;
				next_drive.oe  = periph_oe;
				next_periph_in = pin_level;
			end
			PPIO_INPUT_PULL: begin
				next_drive.pull_up   = ~pull_down_sel;
				next_drive.pull_down = pull_down_sel;
			end
			PPIO_OUTPUT: begin
				next_drive.out = level_out;
				next_drive.oe  = 1'b1;
			end
			PPIO_OPEN_DRAIN: begin
				next_drive.out = 1'b0;
				next_drive.oe  = ~level_out;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			drive     <= '0;
			periph_in <= 1'b1;
		end else begin
			drive     <= next_drive;
			periph_in <= next_periph_in;
		end
	end

endmodule

// File: ppio_unit.sv
`timescale 1ns/1ps
module ppio_unit
	import ppio_pkg::*;
#(
	parameter bit          BYTE_BUS  = 1'b0,
	parameter int unsigned PINS      = PIN_COUNT
)(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire ppio_pcb_req_t    pcb_req,
	output logic [15:0]           pcb_rdata,
	input  wire logic             override_strap_b,
	input  wire logic             srdy_pull_down_sel,
	input  wire logic [PINS-1:0]  pad_in,
	input  wire logic [PINS-1:0]  periph_out,
	input  wire logic [PINS-1:0]  periph_oe,
	output logic [PINS-1:0]       periph_in,
	output logic [PINS-1:0]       pad_out,
	output logic [PINS-1:0]       pad_oe,
	output logic [PINS-1:0]       pad_pull_up,
	output logic [PINS-1:0]       pad_pull_down
);

	// ==========================================================
	// Synchronisers for pins and reset strap
	logic [PINS-1:0] pad_meta;
	logic [PINS-1:0] pad_sync;
	logic            strap_meta;
	logic            strap_sync;

	always_ff @(posedge clk) begin
		pad_meta   <= pad_in;
		pad_sync   <= pad_meta;
		strap_meta <= override_strap_b;
		strap_sync <= strap_meta;
	end

	// ==========================================================
	// Control registers
	logic [31:0] mode;
	logic [31:0] dir;
	logic [31:0] level;
	logic [15:0] rdata_q;
	logic [31:0] next_mode;
	logic [31:0] next_dir;
	logic [31:0] next_level;
	logic [15:0] next_rdata;
	logic [31:0] pin_now;
	logic [1:0]  lanes;
	logic [15:0] lane_mask;
	logic        wr_go;
	logic        rd_go;

	assign pin_now   = 32'(pad_sync);
	assign wr_go     = pcb_req.sel & pcb_req.wr;
	assign rd_go     = pcb_req.sel & pcb_req.rd;
	assign lanes     = BYTE_BUS ? 2'h3 : pcb_req.be;
	assign lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
	                                      input logic [15:0] msk);
		merge = (old & ~msk) | (wd & msk);
	endfunction

	always_comb begin
		next_mode  = mode;
		next_dir   = dir;
		next_level = level;
		next_rdata = rdata_q;
		if (!rst_b) begin
			next_mode  = MODE_RESET;
			next_dir   = strap_sync ? DIR_RESET : (DIR_RESET & ~OVERRIDE_MASK);
			next_level = LEVEL_RESET;
			next_rdata = UNMAPPED_READ;
		end else begin
			// Word-aligned decode; odd addresses alias their word
			if (wr_go) begin
				unique case ({pcb_req.addr[7:1], 1'b0})
					OFS_MODE_LO:  next_mode[15:0]   = merge(mode[15:0], pcb_req.wdata, lane_mask);
					OFS_DIR_LO:   next_dir[15:0]    = merge(dir[15:0], pcb_req.wdata, lane_mask);
					OFS_LEVEL_LO: next_level[15:0]  = merge(level[15:0], pcb_req.wdata, lane_mask);
					OFS_MODE_HI:  next_mode[31:16]  = merge(mode[31:16], pcb_req.wdata, lane_mask);
					OFS_DIR_HI:   next_dir[31:16]   = merge(dir[31:16], pcb_req.wdata, lane_mask);
					OFS_LEVEL_HI: next_level[31:16] = merge(level[31:16], pcb_req.wdata, lane_mask);
					default: ;
				endcase
			end
			if (rd_go) begin
				unique case ({pcb_req.addr[7:1], 1'b0})
					OFS_MODE_LO:  next_rdata = mode[15:0];
					OFS_DIR_LO:   next_rdata = dir[15:0];
					OFS_LEVEL_LO: next_rdata = pin_now[15:0];
					OFS_MODE_HI:  next_rdata = mode[31:16];
					OFS_DIR_HI:   next_rdata = dir[31:16];
					OFS_LEVEL_HI: next_rdata = pin_now[31:16];
					default:      next_rdata = UNMAPPED_READ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		mode    <= next_mode;
		dir     <= next_dir;
		level   <= next_level;
		rdata_q <= next_rdata;
	end

	assign pcb_rdata = rdata_q;

	// ==========================================================
	// Per-pin function cells
	logic [31:0] pull_down_sel;

	// Fixed pull-downs, plus the ready pin's selectable pull-down
	assign pull_down_sel = PULL_DOWN_MASK | (32'(srdy_pull_down_sel) << SRDY_PIN);

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			ppio_drive_t drv;

			ppio_pin_cell u_cell (
				.clk           (clk),
				.rst_b         (rst_b),
				.func          (ppio_func_t'({mode[gi], dir[gi]})),
				.level_out     (level[gi]),
				.pull_down_sel (pull_down_sel[gi]),
				.periph_out    (periph_out[gi]),
				.periph_oe     (periph_oe[gi]),
				.pin_level     (pad_sync[gi]),
				.drive         (drv),
				.periph_in     (periph_in[gi])
			);

			assign pad_out[gi]       = drv.out;
			assign pad_oe[gi]        = drv.oe;
			assign pad_pull_up[gi]   = drv.pull_up;
			assign pad_pull_down[gi] = drv.pull_down;
		end
	endgenerate

endmodule

// File: ppio_assertions.sv
`timescale 1ns/1ps
module ppio_chk
	import ppio_pkg::*;
#(parameter int unsigned PINS = PIN_COUNT)(
	input wire logic            clk,
	input wire logic            rst_b,
	input wire ppio_pcb_req_t   pcb_req,
	input wire logic [15:0]     pcb_rdata,
	input wire logic [PINS-1:0] pad_in,
	input wire logic [PINS-1:0] periph_in,
	input wire logic [PINS-1:0] pad_out,
	input wire logic [PINS-1:0] pad_oe,
	input wire logic [PINS-1:0] pad_pull_up,
	input wire logic [PINS-1:0] pad_pull_down
);
	// ====
	// Port relations
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire rd_hit = pcb_req.sel && pcb_req.rd;
	a_reset_pads_idle: assert property (disable iff (1'b0) !rst_b |=>
		pad_oe == '0 && pad_out == '0 && pad_pull_up == '0 && pad_pull_down == '0 && &periph_in)
		else $error("pads active in reset");
	a_reset_rdata_clear: assert property (disable iff (1'b0) !rst_b |=> pcb_rdata == 16'h0000)
		else $error("read data not cleared");
	a_unmapped_reads_zero: assert property (rd_hit && (pcb_req.addr[7:1] < 7'h38 || pcb_req.addr[7:1] > 7'h3d)
		|=> pcb_rdata == UNMAPPED_READ) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!rd_hit |=> $stable(pcb_rdata)) else $error("read data moved");
	a_pulls_exclusive: assert property ((pad_pull_up & pad_pull_down) == '0 && (pad_oe & pad_pull_up) == '0)
		else $error("pull conflict");
	a_pull_side_fixed: assert property ((pad_pull_up & PULL_DOWN_MASK) == '0
		&& (pad_pull_down & ~(PULL_DOWN_MASK | 32'h0000_0040)) == '0) else $error("pull on wrong side");
	a_periph_in_sync: assert property ($past(rst_b, 4) |-> (~periph_in & $past(pad_in, 3)) == '0)
		else $error("periph_in low without low pin");
	a_level_read_pins: assert property (rd_hit && pcb_req.addr[7:1] == 7'h3a
		&& pad_in[15:0] == $past(pad_in[15:0], 2) |=> pcb_rdata == $past(pad_in[15:0]))
		else $error("level read not pin levels");
endmodule
bind ppio_unit ppio_chk #(.PINS(PINS)) ppio_chk_inst (.clk, .rst_b, .pcb_req, .pcb_rdata, .pad_in,
	.periph_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down);

// File: ppio_pads.sv
`timescale 1ns/1ps
module ppio_pads (
	input  wire logic        clk,
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oe,
	input  wire logic [31:0] pull_up,
	input  wire logic [31:0] pull_down,
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output logic [31:0]      level
);
	// ====
	// Driven, else external, else pulled, else drifting
	logic [31:0] drift = 32'h0000_0000;
	always @(posedge clk) drift <= ~drift;
	assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pull_up | (~pull_down & drift)));
endmodule

// File: ppio_tb.sv
`timescale 1ns/1ps
module testbench;
	import ppio_pkg::*;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          strap_b = 1'b1;
	logic          srdy_pd = 1'b0;
	ppio_pcb_req_t req = '0;
	logic [15:0]   rdata;
	logic [15:0]   rdata_byte;
	logic [31:0]   pad_in, p_in, pad_out, pad_oe, pu, pd;
	logic [31:0]   p_out = 32'h0000_0080, p_oe = 32'h0000_0380;
	logic [31:0]   ext_en = 32'h0000_0000, ext_val = 32'ha5a5_5a5a;
	int            errors = 0, checks = 0, cyc = 0;
	// ====
	// Harness
	always #5 clk = ~clk;
	ppio_unit ppio_unit_inst (.clk, .rst_b, .pcb_req(req), .pcb_rdata(rdata), .override_strap_b(strap_b),
		.srdy_pull_down_sel(srdy_pd), .pad_in, .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
		.pad_out, .pad_oe, .pad_pull_up(pu), .pad_pull_down(pd));
	// Byte-bus variant sharing the same request stream
	ppio_unit #(.BYTE_BUS(1'b1)) ppio_unit_byte_inst (.clk, .rst_b, .pcb_req(req), .pcb_rdata(rdata_byte),
		.override_strap_b(strap_b), .srdy_pull_down_sel(srdy_pd), .pad_in, .periph_out(p_out), .periph_oe(p_oe),
		.periph_in(), .pad_out(), .pad_oe(), .pad_pull_up(), .pad_pull_down());
	ppio_pads ppio_pads_inst (.clk, .pad_out, .pad_oe, .pull_up(pu), .pull_down(pd), .ext_en, .ext_val,
		.level(pad_in));
	task automatic close_out;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			close_out;
		end
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w, input logic [1:0] be);
		@(negedge clk);
		req = '{sel: 1'b1, rd: !w, wr: w, be: be, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		access(a, d, 1'b1, 2'h3);
		repeat (4) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		access(a, 16'h0000, 1'b0, 2'h3);
		check("pcb_rdata", {16'h0000, exp}, {16'h0000, rdata});
	endtask
	task automatic do_reset(input logic s);
		@(negedge clk);
		rst_b = 1'b0;
		strap_b = s;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
	endtask
	// ====
	// Sequence
	initial begin
		do_reset(1'b1);
		rd(OFS_MODE_LO, 16'h0000);
		rd(OFS_DIR_LO, 16'hfc07);
		rd(OFS_DIR_HI, 16'hffff);
		check("pad_oe", 32'h0000_0380, pad_oe);
		check("pad_out", 32'h0000_0080, pad_out);
		check("pad_pull_up", 32'hffff_f805, pu);
		check("pad_pull_down", 32'h0000_0402, pd);
		srdy_pd = 1'b1;
		wr(OFS_DIR_LO, 16'hfcc7);
		check("pad_pull_down", 32'h0000_0442, pd);
		check("pad_pull_up", 32'hffff_f885, pu);
		wr(OFS_MODE_LO, 16'h0003);
		wr(OFS_DIR_LO, 16'hfc06);
		wr(OFS_LEVEL_LO, 16'h0001);
		check("pad_oe", 32'h0000_0383, pad_oe);
		check("pad_out", 32'h0000_0081, pad_out);
		check("pad_pull_up", 32'hffff_f804, pu);
		ext_en = 32'hffff_ffff;
		wr(OFS_LEVEL_LO, 16'h0002);
		rd(OFS_LEVEL_LO, 16'h58da);
		check("periph_in", 32'h0000_0081, p_in & 32'h0000_0181);
		wr(OFS_MODE_HI, 16'h1234);
		rd(OFS_MODE_HI, 16'h1234);
		access(OFS_MODE_HI, 16'hffff, 1'b1, 2'h0);
		rd(OFS_MODE_HI, 16'h1234);
		check("byte_rdata", 32'h0000_ffff, {16'h0000, rdata_byte});
		wr(8'h80, 16'hffff);
		rd(8'h80, 16'h0000);
		do_reset(1'b0);
		rd(OFS_MODE_HI, 16'h0000);
		rd(OFS_DIR_HI, 16'hdbff);
		close_out;
	end
endmodule
